//--- inc/ppsc_pkg.sv
// Constants and state types of the PHY power state controller.
// Assumes a single 125 MHz system clock; all counts derive from it.
package ppsc_pkg;
    // Clock rate in kHz
    localparam int CLK_KHZ = 125000;
    // Break link wait window, milliseconds
    localparam int BREAK_LINK_MIN_MS = 1200;
    localparam int BREAK_LINK_MAX_MS = 1300;
    // Least time rounds up, longest rounds down (both exact at 125 MHz)
    localparam int BREAK_LINK_MIN_CYC = BREAK_LINK_MIN_MS * CLK_KHZ;
    localparam int BREAK_LINK_MAX_CYC = BREAK_LINK_MAX_MS * CLK_KHZ;
    localparam int PWR_CNT_W = 28;
    localparam int TX_CNT_W = 16;
    // Low power idle phase lengths in cycles
    localparam int SLEEP_CYC_DEF = 200;
    localparam int QUIET_CYC_DEF = 2500;
    localparam int REFRESH_CYC_DEF = 25;
    localparam int WAKE_CYC_DEF = 2000;
    localparam int HOLD_CYC_DEF = 1000;
    // Negotiated speed codes
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;
    // Synchroniser reset: {energy, lan pin}, pin idles high
    localparam logic [1:0] SYNC_RST = 2'h1;

    typedef enum logic [7:0] {
        PS_AN = 8'h01,
        PS_LINK = 8'h02,
        PS_CABLE_OFF = 8'h04,
        PS_BREAK_WAIT = 8'h08,
        PS_POWER_DOWN = 8'h10,
        PS_IF_RESET = 8'h20,
        PS_IF_INIT = 8'h40,
        PS_MDIO_CFG = 8'h80
    } ppsc_pwr_e;

    typedef enum logic [5:0] {
        TX_ACTIVE = 6'h01,
        TX_SLEEP = 6'h02,
        TX_QUIET = 6'h04,
        TX_REFRESH = 6'h08,
        TX_WAKE = 6'h10,
        TX_HOLD = 6'h20
    } ppsc_tx_e;
endpackage

//--- rtl/ppsc_sync.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes inputs are slow levels; no pulse shorter than two cycles.
`timescale 1ns/10ps
`default_nettype none
module ppsc_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } ppsc_sync_s;

    ppsc_sync_s sync_reg;
    ppsc_sync_s sync_next;

    // First stage feeds only the second stage
    always_comb begin
        sync_next.s1 = async_in;
        sync_next.s2 = sync_reg.s1;
    end

    // Reset to the idle level of each pin
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync_reg <= {RST_VAL, RST_VAL};
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg.s2;
endmodule
`default_nettype wire

//--- rtl/ppsc_top.sv
// PHY power state controller: cable disconnect, pin power down and
// low power idle sequencing. Assumes same-clock controller inputs;
// lan_disable_low_pin and energy_det arrive asynchronously.
// How it works
// - Cable disconnect enters energy detect mode and powers down PCIe.
// - Energy in cable-disconnect clears cable_unplugged_flag.
// - After energy, wait for break_link_wait before advertising.
// - break_link_wait lasts between 1.2 s and 1.3 s.
// - Cable disconnect sends a one-cycle link-down message.
// - Armed active power down sends wake message when link returns.
// - Pin low enters power down; only pin high leaves it.
// - Response select chooses stay active or full power down.
// - Full power down gates clocks, PHY off, PCIe electrical idle if pcie_link_en.
// - Exit: interface leaves reset, then does link initialization.
// - Controller configures over MDIO, then auto-negotiation runs.
// - LPI transmit request makes the PHY send Sleep symbols.
// - At 100 Mb/s transmit goes quiet right after Sleep.
// - At 1000 Mb/s quiet only after Sleep also received.
// - Quiet periods alternate with Refresh symbol periods.
// - Cleared request sends Wake symbols for a fixed period.
// - Then Active; data waits for remote_wake_hold_time.
// - Partner low power idle is reported to the controller.
// - EEE advertised in negotiation; each direction independent.
// - Negotiation starts at power up, command, error, reconnect.
// - No LPI at half duplex, 10 Mb/s or MDI-X.
// - In sleep states LPI only at 100 Mb/s, receive kept active.
`timescale 1ns/10ps
`default_nettype none
module ppsc_top #(
    parameter int BREAK_LINK_CYCLES = ppsc_pkg::BREAK_LINK_MIN_CYC,
    parameter int SLEEP_CYCLES = ppsc_pkg::SLEEP_CYC_DEF,
    parameter int QUIET_CYCLES = ppsc_pkg::QUIET_CYC_DEF,
    parameter int REFRESH_CYCLES = ppsc_pkg::REFRESH_CYC_DEF,
    parameter int WAKE_CYCLES = ppsc_pkg::WAKE_CYC_DEF,
    parameter int HOLD_CYCLES = ppsc_pkg::HOLD_CYC_DEF
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic lan_disable_low_pin,
    input wire logic energy_det,
    input wire logic cable_disconnect_det,
    input wire logic link_up,
    input wire logic an_done,
    input wire logic an_restart_cmd,
    input wire logic phy_error,
    input wire logic shutdown_response_select,
    input wire logic wake_on_link_event,
    input wire logic active_pd_req,
    input wire logic pcie_link_en,
    input wire logic if_init_done,
    input wire logic mdio_config_done,
    input wire logic lpi_tx_req,
    input wire logic partner_sleep_rx,
    input wire logic partner_lpi,
    input wire logic eee_local_en,
    input wire logic eee_partner_adv,
    input wire logic [1:0] speed,
    input wire logic full_duplex,
    input wire logic mdix_mode,
    input wire logic sx_state,
    output logic cable_unplugged_flag,
    output logic energy_detect_mode,
    output logic pcie_power_down,
    output logic active_power_down,
    output logic link_down_msg,
    output logic wake_msg,
    output logic an_start,
    output logic an_advertise,
    output logic eee_advertise,
    output logic phy_power_down,
    output logic clock_gate,
    output logic pcie_elec_idle,
    output logic if_reset,
    output logic if_link_init,
    output logic tx_sleep_sym,
    output logic tx_quiet,
    output logic tx_refresh_sym,
    output logic tx_wake_sym,
    output logic tx_data_allow,
    output logic rx_lpi_ind,
    output logic rx_power_down
);
    typedef struct packed {
        ppsc_pkg::ppsc_pwr_e ps;
        logic [ppsc_pkg::PWR_CNT_W-1:0] pwr_cnt;
        ppsc_pkg::ppsc_tx_e tx;
        logic [ppsc_pkg::TX_CNT_W-1:0] tx_cnt;
        logic boot;
        logic unplugged;
        logic apd;
        logic pd_full;
        logic eee_on;
        logic sleep_seen;
        logic link_down_msg;
        logic wake_msg;
        logic an_start;
    } ppsc_state_s;

    localparam logic [ppsc_pkg::PWR_CNT_W-1:0] BREAK_LOAD =
        ppsc_pkg::PWR_CNT_W'(BREAK_LINK_CYCLES - 1);
    localparam logic [ppsc_pkg::TX_CNT_W-1:0] SLEEP_LOAD =
        ppsc_pkg::TX_CNT_W'(SLEEP_CYCLES - 1);
    localparam logic [ppsc_pkg::TX_CNT_W-1:0] QUIET_LOAD =
        ppsc_pkg::TX_CNT_W'(QUIET_CYCLES - 1);
    localparam logic [ppsc_pkg::TX_CNT_W-1:0] REFRESH_LOAD =
        ppsc_pkg::TX_CNT_W'(REFRESH_CYCLES - 1);
    localparam logic [ppsc_pkg::TX_CNT_W-1:0] WAKE_LOAD =
        ppsc_pkg::TX_CNT_W'(WAKE_CYCLES - 1);
    localparam logic [ppsc_pkg::TX_CNT_W-1:0] HOLD_LOAD =
        ppsc_pkg::TX_CNT_W'(HOLD_CYCLES - 1);

    ppsc_state_s st_reg;
    ppsc_state_s st_next;
    logic [1:0] sync_out;
    logic pin_high;
    logic energy_s;
    logic lpi_ok;
    logic link_live;

    // LPI is barred at half duplex, 10 Mb/s, MDI-X and non-100 sleep
    function automatic logic lpi_permitted(input logic [1:0] spd,
                                           input logic fdx,
                                           input logic mdix,
                                           input logic sx);
        lpi_permitted = fdx && !mdix && (spd != ppsc_pkg::SPD_10) &&
                        (!sx || spd == ppsc_pkg::SPD_100);
    endfunction

    // Pin and line energy come from outside the clock domain
    ppsc_sync #(
        .WIDTH(2),
        .RST_VAL(ppsc_pkg::SYNC_RST)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .async_in({energy_det, lan_disable_low_pin}),
        .sync_out(sync_out)
    );

    assign pin_high = sync_out[0];
    assign energy_s = sync_out[1];
    assign lpi_ok = st_reg.eee_on &&
                    lpi_permitted(speed, full_duplex, mdix_mode, sx_state);
    // Stay-active power down must not disturb a working link
    assign link_live = st_reg.ps == ppsc_pkg::PS_LINK ||
                       (st_reg.ps == ppsc_pkg::PS_POWER_DOWN &&
                        !st_reg.pd_full);

    // Power state and transmit LPI sequencing
    always_comb begin
        st_next = st_reg;
        st_next.boot = 1'b0;
        st_next.link_down_msg = 1'b0;
        st_next.wake_msg = 1'b0;
        st_next.an_start = st_reg.boot; // power up start
        if (!pin_high) begin
            // Pin overrides every state; response captured on entry
            if (st_reg.ps != ppsc_pkg::PS_POWER_DOWN) begin
                st_next.pd_full = shutdown_response_select;
            end
            st_next.ps = ppsc_pkg::PS_POWER_DOWN;
        end else begin
            case (st_reg.ps)
                ppsc_pkg::PS_AN: begin
                    if (cable_disconnect_det) begin
                        st_next.ps = ppsc_pkg::PS_CABLE_OFF;
                        st_next.unplugged = 1'b1;
                        st_next.link_down_msg = 1'b1;
                    end else if (an_restart_cmd || phy_error) begin
                        st_next.an_start = 1'b1;
                    end else if (an_done && link_up) begin
                        st_next.ps = ppsc_pkg::PS_LINK;
                        // Both sides must offer EEE for this speed
                        st_next.eee_on = eee_local_en &&
                                         eee_partner_adv;
                        if (st_reg.apd) begin
                            st_next.wake_msg = 1'b1;
                            st_next.apd = 1'b0;
                        end
                    end
                end
                ppsc_pkg::PS_LINK: begin
                    if (cable_disconnect_det) begin
                        st_next.ps = ppsc_pkg::PS_CABLE_OFF;
                        st_next.unplugged = 1'b1;
                        st_next.link_down_msg = 1'b1;
                    end else if (an_restart_cmd || phy_error) begin
                        st_next.ps = ppsc_pkg::PS_AN;
                        st_next.an_start = 1'b1;
                        st_next.eee_on = 1'b0;
                    end
                end
                ppsc_pkg::PS_CABLE_OFF: begin
                    // Driver arms wake on link change, then powers down
                    if (wake_on_link_event && active_pd_req) begin
                        st_next.apd = 1'b1;
                    end
                    if (energy_s) begin
                        st_next.unplugged = 1'b0;
                        st_next.ps = ppsc_pkg::PS_BREAK_WAIT;
                        st_next.pwr_cnt = BREAK_LOAD;
                    end
                end
                ppsc_pkg::PS_BREAK_WAIT: begin
                    // Nothing advertised until the timer runs out
                    if (st_reg.pwr_cnt == '0) begin
                        st_next.ps = ppsc_pkg::PS_AN;
                        st_next.an_start = 1'b1; // reconnect
                    end else begin
                        st_next.pwr_cnt = st_reg.pwr_cnt - 1'b1;
                    end
                end
                ppsc_pkg::PS_POWER_DOWN: begin
                    // Stay-active response never lost state, so skip
                    if (st_reg.pd_full) begin
                        st_next.ps = ppsc_pkg::PS_IF_RESET;
                    end else begin
                        st_next.ps = ppsc_pkg::PS_LINK;
                    end
                end
                ppsc_pkg::PS_IF_RESET: begin
                    st_next.ps = ppsc_pkg::PS_IF_INIT;
                end
                ppsc_pkg::PS_IF_INIT: begin
                    if (if_init_done) begin
                        st_next.ps = ppsc_pkg::PS_MDIO_CFG;
                    end
                end
                ppsc_pkg::PS_MDIO_CFG: begin
                    // Configuration must end before any power-down bit
                    if (mdio_config_done) begin
                        st_next.ps = ppsc_pkg::PS_AN;
                        st_next.an_start = 1'b1;
                        st_next.eee_on = 1'b0;
                    end
                end
                default: begin
                    st_next.ps = ppsc_pkg::PS_AN;
                end
            endcase
        end

        // Transmit LPI runs only with an established link
        if (!link_live) begin
            st_next.tx = ppsc_pkg::TX_ACTIVE;
            st_next.tx_cnt = '0;
        end else begin
            case (st_reg.tx)
                ppsc_pkg::TX_ACTIVE: begin
                    if (lpi_tx_req && lpi_ok) begin
                        st_next.tx = ppsc_pkg::TX_SLEEP;
                        st_next.tx_cnt = SLEEP_LOAD;
                        st_next.sleep_seen = 1'b0;
                    end
                end
                ppsc_pkg::TX_SLEEP: begin
                    if (partner_sleep_rx) begin
                        st_next.sleep_seen = 1'b1;
                    end
                    if (!lpi_tx_req) begin
                        st_next.tx = ppsc_pkg::TX_WAKE;
                        st_next.tx_cnt = WAKE_LOAD;
                    end else if (st_reg.tx_cnt != '0) begin
                        st_next.tx_cnt = st_reg.tx_cnt - 1'b1;
                    end else if (speed == ppsc_pkg::SPD_100) begin
                        st_next.tx = ppsc_pkg::TX_QUIET;
                        st_next.tx_cnt = QUIET_LOAD;
                    end else if (st_reg.sleep_seen) begin
                        // Gigabit keeps sending Sleep until echoed
                        st_next.tx = ppsc_pkg::TX_QUIET;
                        st_next.tx_cnt = QUIET_LOAD;
                    end
                end
                ppsc_pkg::TX_QUIET: begin
                    if (!lpi_tx_req) begin
                        st_next.tx = ppsc_pkg::TX_WAKE;
                        st_next.tx_cnt = WAKE_LOAD;
                    end else if (st_reg.tx_cnt == '0) begin
                        st_next.tx = ppsc_pkg::TX_REFRESH;
                        st_next.tx_cnt = REFRESH_LOAD;
                    end else begin
                        st_next.tx_cnt = st_reg.tx_cnt - 1'b1;
                    end
                end
                ppsc_pkg::TX_REFRESH: begin
                    if (!lpi_tx_req) begin
                        st_next.tx = ppsc_pkg::TX_WAKE;
                        st_next.tx_cnt = WAKE_LOAD;
                    end else if (st_reg.tx_cnt == '0) begin
                        st_next.tx = ppsc_pkg::TX_QUIET;
                        st_next.tx_cnt = QUIET_LOAD;
                    end else begin
                        st_next.tx_cnt = st_reg.tx_cnt - 1'b1;
                    end
                end
                ppsc_pkg::TX_WAKE: begin
                    if (st_reg.tx_cnt == '0) begin
                        st_next.tx = ppsc_pkg::TX_HOLD;
                        st_next.tx_cnt = HOLD_LOAD;
                    end else begin
                        st_next.tx_cnt = st_reg.tx_cnt - 1'b1;
                    end
                end
                ppsc_pkg::TX_HOLD: begin
                    // Active again, but partner needs time to wake
                    if (st_reg.tx_cnt == '0) begin
                        st_next.tx = ppsc_pkg::TX_ACTIVE;
                    end else begin
                        st_next.tx_cnt = st_reg.tx_cnt - 1'b1;
                    end
                end
                default: begin
                    st_next.tx = ppsc_pkg::TX_ACTIVE;
                end
            endcase
        end
    end

    // State register; boot flag launches the first negotiation
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '{ps: ppsc_pkg::PS_AN, tx: ppsc_pkg::TX_ACTIVE,
                        boot: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // Decoded outputs from registered state; eee_advertise, pcie_elec_idle and receive LPI also use inputs
    assign cable_unplugged_flag = st_reg.unplugged;
    assign energy_detect_mode = st_reg.ps == ppsc_pkg::PS_CABLE_OFF;
    assign pcie_power_down = st_reg.ps == ppsc_pkg::PS_CABLE_OFF;
    assign active_power_down = st_reg.apd;
    assign link_down_msg = st_reg.link_down_msg;
    assign wake_msg = st_reg.wake_msg;
    assign an_start = st_reg.an_start;
    assign an_advertise = st_reg.ps == ppsc_pkg::PS_AN;
    assign eee_advertise = an_advertise && eee_local_en;
    assign phy_power_down = st_reg.ps == ppsc_pkg::PS_POWER_DOWN &&
                            st_reg.pd_full;
    assign clock_gate = phy_power_down;
    assign pcie_elec_idle = phy_power_down && pcie_link_en;
    assign if_reset = phy_power_down ||
                      st_reg.ps == ppsc_pkg::PS_IF_RESET;
    assign if_link_init = st_reg.ps == ppsc_pkg::PS_IF_INIT;
    assign tx_sleep_sym = st_reg.tx == ppsc_pkg::TX_SLEEP;
    assign tx_quiet = st_reg.tx == ppsc_pkg::TX_QUIET;
    assign tx_refresh_sym = st_reg.tx == ppsc_pkg::TX_REFRESH;
    assign tx_wake_sym = st_reg.tx == ppsc_pkg::TX_WAKE;
    assign tx_data_allow = link_live && st_reg.tx == ppsc_pkg::TX_ACTIVE;
    // Receive side stays powered in system sleep states
    assign rx_lpi_ind = link_live && partner_lpi &&
                        lpi_ok;
    assign rx_power_down = rx_lpi_ind && !sx_state;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence s_pd_exit;
        st_reg.ps == ppsc_pkg::PS_POWER_DOWN && pin_high && st_reg.pd_full;
    endsequence
    sequence s_if_steps;
        if_reset ##1 (if_link_init && !if_reset);
    endsequence

    AST_CABLE_ENTER: assert property (
        pin_high && st_reg.ps == ppsc_pkg::PS_LINK && cable_disconnect_det
        |=> energy_detect_mode && pcie_power_down && link_down_msg
        ##1 !link_down_msg)
        else $error("cable disconnect entry wrong");
    AST_FLAG_CLEAR: assert property (
        pin_high && energy_detect_mode && energy_s
        |=> !cable_unplugged_flag && st_reg.ps == ppsc_pkg::PS_BREAK_WAIT)
        else $error("unplugged flag not cleared on energy");
    AST_BREAK_HOLD: assert property (
        pin_high && st_reg.ps == ppsc_pkg::PS_BREAK_WAIT &&
        st_reg.pwr_cnt != '0 |=> !an_advertise && !an_start)
        else $error("advertising before break wait ends");
    AST_BREAK_LOAD: assert property (
        $rose(st_reg.ps == ppsc_pkg::PS_BREAK_WAIT) |->
        st_reg.pwr_cnt == BREAK_LOAD ##1
        (st_reg.ps != ppsc_pkg::PS_BREAK_WAIT ||
        st_reg.pwr_cnt == BREAK_LOAD - 1))
        else $error("break wait count wrong");
    AST_WAKE_MSG: assert property (
        pin_high && st_reg.ps == ppsc_pkg::PS_AN && st_reg.apd && an_done &&
        link_up && !cable_disconnect_det && !an_restart_cmd && !phy_error
        |=> wake_msg && !active_power_down)
        else $error("wake message missing");
    AST_PD_ENTER: assert property (
        !pin_high |=> st_reg.ps == ppsc_pkg::PS_POWER_DOWN)
        else $error("pin low did not power down");
    AST_PD_STAY: assert property (
        st_reg.ps == ppsc_pkg::PS_POWER_DOWN && !st_reg.pd_full |->
        !phy_power_down && !clock_gate && !if_reset)
        else $error("stay-active response reduced power");
    AST_PD_FULL: assert property (
        $past(!pin_high) && !pin_high && $past(shutdown_response_select) &&
        $past(st_reg.ps) != ppsc_pkg::PS_POWER_DOWN
        |=> phy_power_down && clock_gate &&
        (pcie_elec_idle == pcie_link_en))
        else $error("full power down incomplete");
    AST_EXIT_SEQ: assert property (
        s_pd_exit |=> s_if_steps)
        else $error("interface exit order wrong");
    AST_TX_100: assert property (
        st_reg.ps == ppsc_pkg::PS_LINK && tx_sleep_sym && lpi_tx_req &&
        st_reg.tx_cnt == '0 && speed == ppsc_pkg::SPD_100 |=> tx_quiet)
        else $error("100M quiet entry late");
    AST_TX_1000: assert property (
        st_reg.ps == ppsc_pkg::PS_LINK && tx_sleep_sym &&
        !st_reg.sleep_seen && speed == ppsc_pkg::SPD_1000 |=> !tx_quiet)
        else $error("1000M quiet before remote sleep");
    AST_WAKE_SYM: assert property (
        st_reg.ps == ppsc_pkg::PS_LINK && (tx_quiet || tx_refresh_sym) &&
        !lpi_tx_req && pin_high && !cable_disconnect_det &&
        !an_restart_cmd && !phy_error |=> tx_wake_sym && !tx_data_allow)
        else $error("wake symbols not sent");
    AST_LPI_BAN: assert property (
        (!full_duplex || mdix_mode || speed == ppsc_pkg::SPD_10) |->
        !rx_lpi_ind ##1 (st_reg.tx != ppsc_pkg::TX_SLEEP ||
        $past(st_reg.tx) == ppsc_pkg::TX_SLEEP))
        else $error("LPI used where barred");
    AST_RX_SX: assert property (
        rx_lpi_ind |-> partner_lpi && (rx_power_down == !sx_state))
        else $error("receive LPI report wrong");
endmodule
`default_nettype wire

//--- bench/ppsc_ctrl_model.sv
// Controller stand-in: answers interface init, then MDIO configuration.
// Assumes the same-clock handshake levels of the power state machine.
`timescale 1ns/10ps
`default_nettype none
module ppsc_ctrl_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic if_link_init,
    input wire logic an_start,
    output logic if_init_done,
    output logic mdio_config_done
);
    logic [2:0] cnt_reg;
    logic cfg_reg;
    // Answers slowly, holding each level until the design moves on
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 3'h0;
            cfg_reg <= 1'b0;
            if_init_done <= 1'b0;
            mdio_config_done <= 1'b0;
        end else begin
            cnt_reg <= if_link_init ? cnt_reg + 3'h1 : 3'h0;
            if_init_done <= if_link_init && cnt_reg >= 3'h3;
            cfg_reg <= if_init_done | (cfg_reg & ~an_start);
            mdio_config_done <= cfg_reg & ~an_start;
        end
    end
endmodule
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the PHY power state controller.
// Assumes the controller stand-in answers the exit handshakes.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk_sys = 0, rst_b = 0;
    logic [18:0] v = 19'h1;
    logic [1:0] sp = 2'h1;
    logic [20:0] o;
    logic ido, mdo;
    int err_total = 0, check_count = 0, cyc = 0, n;
    ppsc_top #(.BREAK_LINK_CYCLES(20), .SLEEP_CYCLES(4), .QUIET_CYCLES(6),
        .WAKE_CYCLES(4), .HOLD_CYCLES(4)) u_ppsc_top (
        .clk_sys(clk_sys), .rst_b(rst_b), .lan_disable_low_pin(v[0]),
        .energy_det(v[1]), .cable_disconnect_det(v[2]), .link_up(v[3]),
        .an_done(v[4]), .an_restart_cmd(v[5]), .phy_error(v[6]),
        .shutdown_response_select(v[7]), .wake_on_link_event(v[8]),
        .active_pd_req(v[9]), .pcie_link_en(v[10]), .if_init_done(ido),
        .mdio_config_done(mdo), .lpi_tx_req(v[11]),
        .partner_sleep_rx(v[12]), .partner_lpi(v[13]),
        .eee_local_en(v[14]), .eee_partner_adv(v[15]), .speed(sp),
        .full_duplex(v[16]), .mdix_mode(v[17]), .sx_state(v[18]),
        .cable_unplugged_flag(o[0]), .energy_detect_mode(o[1]),
        .pcie_power_down(o[2]), .active_power_down(o[3]),
        .link_down_msg(o[4]), .wake_msg(o[5]), .an_start(o[6]),
        .an_advertise(o[7]), .eee_advertise(o[8]), .phy_power_down(o[9]),
        .clock_gate(o[10]), .pcie_elec_idle(o[11]), .if_reset(o[12]),
        .if_link_init(o[13]), .tx_sleep_sym(o[14]), .tx_quiet(o[15]),
        .tx_refresh_sym(o[16]), .tx_wake_sym(o[17]),
        .tx_data_allow(o[18]), .rx_lpi_ind(o[19]), .rx_power_down(o[20]));
    ppsc_ctrl_model u_ppsc_ctrl_model (.clk_sys(clk_sys), .rst_b(rst_b),
        .if_link_init(o[13]), .an_start(o[6]), .if_init_done(ido),
        .mdio_config_done(mdo));
    // Clock and hang guard
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic s(input int k, input logic b);
        @(posedge clk_sys);
        v[k] <= b;
    endtask
    // Bounded wait on an output level, sampled at the falling edge
    task automatic w(input int k, input logic b, output int c);
        c = 0;
        while (o[k] !== b && c < 400) begin
            @(negedge clk_sys);
            c++;
        end
        if (c == 400) chk(8'h0, 8'h1);
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Test sequence: link, idle modes, cable pull, pin power down
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        w(6, 1, n); chk(o[7], 1);
        @(posedge clk_sys);
        v <= 19'h1c019;
        w(18, 1, n); chk(o[8], 0);
        $display("test link done");
        s(11, 1); w(14, 1, n); w(15, 1, n); chk(o[14], 0);
        w(16, 1, n); chk(o[15], 0);
        s(11, 0); w(17, 1, n); chk(o[18], 0);
        w(18, 1, n); chk(o[17], 0);
        s(13, 1); @(negedge clk_sys); chk({o[19], o[20]}, 3);
        s(17, 1); @(negedge clk_sys); chk(o[19], 0);
        s(18, 1); s(17, 0); @(negedge clk_sys); chk(o[20:19], 1);
        s(18, 0); s(13, 0); @(posedge clk_sys); sp <= 2'h2;
        s(11, 1); w(14, 1, n); repeat (8) @(negedge clk_sys);
        chk(o[15], 0); s(12, 1); w(15, 1, n);
        s(11, 0); s(12, 0); w(18, 1, n);
        $display("test idle done");
        s(2, 1); w(4, 1, n); chk(o[2:0], 7);
        s(2, 0); s(3, 0); s(4, 0); s(8, 1); s(9, 1); s(1, 1);
        w(0, 0, n); chk(o[7], 0);
        w(6, 1, n); chk(n >= 19 && n <= 21, 1);
        s(1, 0); s(3, 1); s(4, 1); w(5, 1, n); chk(o[3], 0);
        $display("test cable done");
        s(7, 1); s(10, 1); s(0, 0); w(9, 1, n);
        chk({o[10], o[11], o[12]}, 7);
        s(0, 1); w(9, 0, n); w(13, 1, n);
        w(6, 1, n); w(18, 1, n);
        s(7, 0); s(0, 0); repeat (6) @(negedge clk_sys);
        chk({o[9], o[10], o[18]}, 1); s(0, 1);
        s(5, 1);
        w(6, 1, n);
        chk(o[7], 1);
        $display("test power down done");
        final_report();
    end
endmodule
`default_nettype wire
